// File: mcc_clk_div.sv
// Optional divide-by-two of the system clock, given as a clock enable.
// Assumes the datapath outside gates its registers with o_clk_en.
`timescale 1ns/10ps
module mcc_clk_div (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_div2,
   output logic o_clk_en
);

   typedef struct packed {
      logic phase;
      logic en;
   } mcc_div_state_t;

   mcc_div_state_t q;
   mcc_div_state_t d;

   always_comb begin
      d = q;
      // Phase runs freely so the enable stays at half rate with even spacing
      d.phase = ~q.phase;
      d.en = i_div2 ? q.phase : 1'b1;
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_clk_en = q.en;

endmodule

// File: mcc_ctrl_status.sv
// Control and status registers of the motion coprocessor, on its parallel host bus.
// Assumes the host strobes are asynchronous and held at least four clocks,
// and that the converter and transform datapath run on the same clock.
`timescale 1ns/10ps

module mcc_ctrl_status #(
   parameter int DATA_W = mcc_pkg::DATA_W,
   parameter logic [3:0] IRQ_PULSE = mcc_pkg::IRQ_PULSE_CYC
) (
   input wire logic i_clock,
   input wire logic i_rst_b,
   // Host bus pins
   input wire logic i_cs_b,
   input wire logic i_rd_b,
   input wire logic i_wr_b,
   input wire logic [mcc_pkg::ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_data,
   output logic [DATA_W-1:0] o_data,
   output logic o_data_oe,
   // Open-drain interrupt request, low when driven
   output logic o_irq_b,
   output logic o_irq_oe,
   // Converter side
   input wire logic i_conv_valid,
   input wire logic [1:0] i_conv_chan,
   input wire logic [DATA_W-1:0] i_conv_data,
   input wire logic i_conv_done,
   output logic o_conv_u_en,
   output logic o_conv_aux_en,
   // Transform datapath side
   output logic o_xf_fwd_start,
   output logic o_xf_rev_start,
   output logic [DATA_W-1:0] o_xf_angle,
   output logic [DATA_W-1:0] o_xf_in_1,
   output logic [DATA_W-1:0] o_xf_in_2,
   output logic [DATA_W-1:0] o_xf_in_3,
   output logic o_xf_three_phase,
   input wire logic i_xf_done,
   input wire logic [DATA_W-1:0] i_xf_res_0,
   input wire logic [DATA_W-1:0] i_xf_res_1,
   input wire logic [DATA_W-1:0] i_xf_res_2,
   input wire logic [DATA_W-1:0] i_xf_res_3,
   // System clock enable for the datapath
   output logic o_sys_clk_en
);

   if (DATA_W != 12) begin : g_width_check
      $error("mcc_ctrl_status supports a 12-bit data bus only");
   end

   typedef struct packed {
      // Pin synchronisers; stage 1 feeds stage 2 only
      logic cs_s1;
      logic cs_s2;
      logic cs_s3;
      logic rd_s1;
      logic rd_s2;
      logic rd_s3;
      logic wr_s1;
      logic wr_s2;
      logic wr_s3;
      logic [3:0] addr_s1;
      logic [3:0] addr_s2;
      logic [11:0] data_s1;
      logic [11:0] data_s2;
      // Registers
      logic [11:0] ctrl;
      logic [11:0] angle;
      logic [2:0][11:0] phase_in;
      logic [3:0][11:0] result;
      logic [3:0][11:0] conv;
      // Status
      logic st_conv;
      logic st_xf;
      logic st_valid;
      logic st_irq;
      // Outputs
      logic fwd_start;
      logic rev_start;
      logic [11:0] rdata;
      logic rd_oe;
      logic [3:0] irq_cnt;
      logic irq_oe;
   } mcc_state_t;

   mcc_state_t q;
   mcc_state_t d;

   function automatic logic [11:0] status_word(input mcc_state_t s);
      logic [11:0] w;
      w = 12'h000;
      w[mcc_pkg::STAT_CONV_DONE] = s.st_conv;
      w[mcc_pkg::STAT_XF_DONE] = s.st_xf;
      w[mcc_pkg::STAT_RESULT_VALID] = s.st_valid;
      w[mcc_pkg::STAT_IRQ_SOURCE] = s.st_irq;
      return w;
   endfunction

   always_comb begin
      logic wr_edge;
      logic rd_active;
      logic rd_end;
      logic conv_evt;
      logic xf_evt;
      logic [11:0] rword;
      wr_edge = 1'b0;
      rd_active = 1'b0;
      rd_end = 1'b0;
      conv_evt = 1'b0;
      xf_evt = 1'b0;
      rword = 12'h000;
      d = q;

      // Two flops before any use; the third flop forms the strobe edges and holds select from one cycle earlier
      d.cs_s1 = i_cs_b;
      d.cs_s2 = q.cs_s1;
      d.cs_s3 = q.cs_s2;
      d.rd_s1 = i_rd_b;
      d.rd_s2 = q.rd_s1;
      d.rd_s3 = q.rd_s2;
      d.wr_s1 = i_wr_b;
      d.wr_s2 = q.wr_s1;
      d.wr_s3 = q.wr_s2;
      d.addr_s1 = i_addr;
      d.addr_s2 = q.addr_s1;
      d.data_s1 = i_data;
      d.data_s2 = q.data_s1;

      // Select is taken as it stood while the strobe was still low
      wr_edge = q.wr_s2 & ~q.wr_s3 & ~q.cs_s3;
      rd_active = ~q.rd_s2 & ~q.cs_s2;
      rd_end = q.rd_s2 & ~q.rd_s3 & ~q.cs_s3;

      d.fwd_start = 1'b0;
      d.rev_start = 1'b0;

      if (wr_edge) begin
         case (q.addr_s2)
            mcc_pkg::ADDR_REVERSE_ANGLE: begin
               d.angle = q.data_s2;
               d.rev_start = 1'b1;
            end
            mcc_pkg::ADDR_PHASE_IN_1: begin
               d.phase_in[0] = q.data_s2;
            end
            mcc_pkg::ADDR_PHASE_IN_2: begin
               d.phase_in[1] = q.data_s2;
            end
            mcc_pkg::ADDR_PHASE_IN_3: begin
               d.phase_in[2] = q.data_s2;
            end
            mcc_pkg::ADDR_FORWARD_ANGLE: begin
               d.angle = q.data_s2;
               d.fwd_start = 1'b1;
            end
            mcc_pkg::ADDR_SYSTEM_CONTROL: begin
               // Reserved bits are not stored, so a stray one cannot steer anything
               d.ctrl = q.data_s2 & mcc_pkg::CTRL_MASK;
            end
            default: begin
               // Reserved and unhandled locations are ignored
               d.ctrl = q.ctrl;
            end
         endcase
      end

      // Conversion results go out with the lowest bit forced clear
      if (i_conv_valid) begin
         d.conv[i_conv_chan] = i_conv_data & mcc_pkg::CONV_LSB_CLEAR;
      end

      // Clarke intermediates occupy result slots 2 and 3 in reverse mode
      if (i_xf_done) begin
         d.result[0] = i_xf_res_0;
         d.result[1] = i_xf_res_1;
         d.result[2] = i_xf_res_2;
         d.result[3] = i_xf_res_3;
      end

      conv_evt = i_conv_done & q.ctrl[mcc_pkg::CTRL_CONV_IRQ_EN];
      xf_evt = i_xf_done & q.ctrl[mcc_pkg::CTRL_XF_IRQ_EN];

      // Clear by read first so that a completion in the same cycle survives
      if (rd_end && q.addr_s2 == mcc_pkg::ADDR_SYSTEM_STATUS) begin
         d.st_conv = 1'b0;
         d.st_xf = 1'b0;
         d.st_irq = 1'b0;
      end
      if (conv_evt) begin
         d.st_conv = 1'b1;
      end
      if (xf_evt) begin
         d.st_xf = 1'b1;
      end
      if (conv_evt || xf_evt) begin
         d.st_irq = 1'b1;
      end

      // A start invalidates old results until the new ones land
      if (q.fwd_start || q.rev_start) begin
         d.st_valid = 1'b0;
      end
      if (i_xf_done) begin
         d.st_valid = 1'b1;
      end

      // Edge mode: a fixed low pulse per event; level mode follows the flags
      if (conv_evt || xf_evt) begin
         d.irq_cnt = IRQ_PULSE;
      end else if (q.irq_cnt != 4'h0) begin
         d.irq_cnt = q.irq_cnt - 4'h1;
      end
      if (q.ctrl[mcc_pkg::CTRL_IRQ_LEVEL]) begin
         d.irq_oe = d.st_conv | d.st_xf;
      end else begin
         d.irq_oe = d.irq_cnt != 4'h0;
      end

      case (q.addr_s2)
         mcc_pkg::ADDR_RESULT_0: begin
            rword = q.result[0];
         end
         mcc_pkg::ADDR_RESULT_1: begin
            rword = q.result[1];
         end
         mcc_pkg::ADDR_RESULT_2: begin
            rword = q.result[2];
         end
         mcc_pkg::ADDR_RESULT_3: begin
            rword = q.result[3];
         end
         mcc_pkg::ADDR_CONV_U: begin
            rword = q.conv[mcc_pkg::CHAN_U];
         end
         mcc_pkg::ADDR_CONV_V: begin
            rword = q.conv[mcc_pkg::CHAN_V];
         end
         mcc_pkg::ADDR_CONV_W: begin
            rword = q.conv[mcc_pkg::CHAN_W];
         end
         mcc_pkg::ADDR_CONV_AUX: begin
            rword = q.conv[mcc_pkg::CHAN_AUX];
         end
         mcc_pkg::ADDR_SYSTEM_CONTROL: begin
            rword = q.ctrl;
         end
         mcc_pkg::ADDR_SYSTEM_STATUS: begin
            rword = status_word(q);
         end
         default: begin
            rword = 12'h000;
         end
      endcase

      // Data freezes at the end of the read so the host sees stable bits
      if (rd_active) begin
         d.rdata = rword;
      end
      d.rd_oe = rd_active;
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         q <= '0;
         q.cs_s1 <= 1'b1;
         q.cs_s2 <= 1'b1;
         q.cs_s3 <= 1'b1;
         q.rd_s1 <= 1'b1;
         q.rd_s2 <= 1'b1;
         q.rd_s3 <= 1'b1;
         q.wr_s1 <= 1'b1;
         q.wr_s2 <= 1'b1;
         q.wr_s3 <= 1'b1;
         q.ctrl <= mcc_pkg::CTRL_RESET;
         q.st_valid <= mcc_pkg::STAT_VALID_RESET;
      end else begin
         q <= d;
      end
   end

   mcc_clk_div u_clk_div (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_div2(q.ctrl[mcc_pkg::CTRL_CLK_DIV2]),
      .o_clk_en(o_sys_clk_en)
   );

   assign o_data = q.rdata;
   assign o_data_oe = q.rd_oe;
   assign o_irq_b = 1'b0;
   assign o_irq_oe = q.irq_oe;
   // Channel set: V and W always, U and auxiliary on request
   assign o_conv_u_en = q.ctrl[mcc_pkg::CTRL_U_EN];
   assign o_conv_aux_en = q.ctrl[mcc_pkg::CTRL_AUX_EN];
   assign o_xf_fwd_start = q.fwd_start;
   assign o_xf_rev_start = q.rev_start;
   // Inputs are live register contents, so the start uses what stands now
   assign o_xf_angle = q.angle;
   assign o_xf_in_1 = q.phase_in[0];
   assign o_xf_in_2 = q.phase_in[1];
   assign o_xf_in_3 = q.phase_in[2];
   assign o_xf_three_phase = q.ctrl[mcc_pkg::CTRL_THREE_PHASE];

endmodule

// File: mcc_ctrl_status_monitor.sv
// Checker for the control and status block, bound to its top module.
// Assumes the host holds address and strobes steady across each access.
`timescale 1ns/10ps
module mcc_ctrl_status_checker (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_cs_b,
   input wire logic i_rd_b,
   input wire logic i_wr_b,
   input wire logic [3:0] i_addr,
   input wire logic i_conv_done,
   input wire logic i_xf_done,
   input wire logic [11:0] o_data,
   input wire logic o_data_oe,
   input wire logic o_irq_oe,
   input wire logic o_xf_fwd_start,
   input wire logic o_xf_rev_start,
   input wire logic o_sys_clk_en
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   a_fwd_start_write: assert property ($rose(i_wr_b) && !i_cs_b && i_addr == 4'h4 |-> ##[2:5] o_xf_fwd_start)
      else $error("forward start missing after angle write");
   a_rev_start_write: assert property ($rose(i_wr_b) && !i_cs_b && i_addr == 4'h0 |-> ##[2:5] o_xf_rev_start)
      else $error("reverse start missing after angle write");
   a_start_one_cycle: assert property (o_xf_fwd_start || o_xf_rev_start |=> !o_xf_fwd_start && !o_xf_rev_start)
      else $error("start pulse longer than one cycle");
   a_div_alternate: assert property ($fell(o_sys_clk_en) |=> o_sys_clk_en)
      else $error("clock enable low for two cycles");
   a_irq_has_cause: assert property ($rose(o_irq_oe) |-> $past(i_conv_done || i_xf_done)
      || $past(i_conv_done || i_xf_done, 2))
      else $error("interrupt without a source");
   a_irq_min_width: assert property ($rose(o_irq_oe) |-> o_irq_oe [*4])
      else $error("interrupt request too short");
   a_read_drive: assert property ($rose(o_data_oe) |-> !i_rd_b && !i_cs_b && $past(!i_rd_b, 2))
      else $error("data bus driven without a read");
   a_oe_released: assert property (i_rd_b && $past(i_rd_b, 4) |-> !o_data_oe)
      else $error("data bus still driven after read");
   a_conv_lsb_zero: assert property (o_data_oe && i_addr inside {4'h5, 4'h6, 4'h7, 4'h8} |-> !o_data[0])
      else $error("conversion result bit 0 set");
   a_reserved_zero: assert property (o_data_oe && i_addr inside {4'h4, 4'h9, 4'ha, 4'hb, 4'hc, 4'hf}
      |-> o_data == 12'h000)
      else $error("reserved read not zero");
   c_fwd: cover property (o_xf_fwd_start);
   c_irq: cover property ($rose(o_irq_oe));
   c_div: cover property ($fell(o_sys_clk_en));
endmodule
bind mcc_ctrl_status mcc_ctrl_status_checker chk_u (.i_clock, .i_rst_b, .i_cs_b, .i_rd_b, .i_wr_b, .i_addr,
   .i_conv_done, .i_xf_done, .o_data, .o_data_oe, .o_irq_oe, .o_xf_fwd_start, .o_xf_rev_start, .o_sys_clk_en);

// File: mcc_host_model.sv
// Host processor model on the parallel register bus.
// Assumes the bench calls wr and rd; pins move only on falling edges.
`timescale 1ns/10ps
module mcc_host_model (
   input wire logic i_clock,
   input wire logic [11:0] i_data,
   output logic o_cs_b,
   output logic o_rd_b,
   output logic o_wr_b,
   output logic [3:0] o_addr,
   output logic [11:0] o_data
);
   initial begin
      o_cs_b = 1'b1;
      o_rd_b = 1'b1;
      o_wr_b = 1'b1;
      o_addr = 4'h0;
      o_data = 12'h000;
   end
   // Strobes held well past the synchronisers; data held after the rising edge
   task automatic wr(input logic [3:0] a, input logic [11:0] d);
      @(negedge i_clock);
      o_cs_b = 1'b0;
      o_addr = a;
      o_data = d;
      repeat (3) @(negedge i_clock);
      o_wr_b = 1'b0;
      repeat (5) @(negedge i_clock);
      o_wr_b = 1'b1;
      repeat (4) @(negedge i_clock);
      o_cs_b = 1'b1;
      // Released bus shows a changed value, not the last one
      o_data = ~d;
      repeat (4) @(negedge i_clock);
   endtask
   task automatic rd(input logic [3:0] a, output logic [11:0] q);
      @(negedge i_clock);
      o_cs_b = 1'b0;
      o_addr = a;
      o_rd_b = 1'b0;
      repeat (5) @(negedge i_clock);
      q = i_data;
      repeat (2) @(negedge i_clock);
      o_rd_b = 1'b1;
      repeat (4) @(negedge i_clock);
      o_cs_b = 1'b1;
      repeat (2) @(negedge i_clock);
   endtask
endmodule

// File: mcc_pkg.sv
// Constants shared by the motion coprocessor control and status block.
// Assumes a single 20 MHz clock; every count here derives from that period.
package mcc_pkg;

   // Clock
   localparam int CLK_PERIOD_NS = 50;

   // Register bus
   localparam int ADDR_W = 4;
   localparam int DATA_W = 12;

   // Write map (register index equals address)
   localparam logic [3:0] ADDR_REVERSE_ANGLE = 4'h0;
   localparam logic [3:0] ADDR_PHASE_IN_1 = 4'h1;
   localparam logic [3:0] ADDR_PHASE_IN_2 = 4'h2;
   localparam logic [3:0] ADDR_PHASE_IN_3 = 4'h3;
   localparam logic [3:0] ADDR_FORWARD_ANGLE = 4'h4;
   localparam logic [3:0] ADDR_SYSTEM_CONTROL = 4'hd;

   // Read map
   localparam logic [3:0] ADDR_RESULT_0 = 4'h0;
   localparam logic [3:0] ADDR_RESULT_1 = 4'h1;
   localparam logic [3:0] ADDR_RESULT_2 = 4'h2;
   localparam logic [3:0] ADDR_RESULT_3 = 4'h3;
   localparam logic [3:0] ADDR_CONV_V = 4'h5;
   localparam logic [3:0] ADDR_CONV_W = 4'h6;
   localparam logic [3:0] ADDR_CONV_AUX = 4'h7;
   localparam logic [3:0] ADDR_CONV_U = 4'h8;
   localparam logic [3:0] ADDR_SYSTEM_STATUS = 4'he;

   // Conversion channel codes on the converter result port
   localparam logic [1:0] CHAN_U = 2'h0;
   localparam logic [1:0] CHAN_V = 2'h1;
   localparam logic [1:0] CHAN_W = 2'h2;
   localparam logic [1:0] CHAN_AUX = 2'h3;

   // System control fields
   localparam int CTRL_U_EN = 3;
   localparam int CTRL_AUX_EN = 4;
   localparam int CTRL_CLK_DIV2 = 5;
   localparam int CTRL_XF_IRQ_EN = 6;
   localparam int CTRL_CONV_IRQ_EN = 7;
   localparam int CTRL_IRQ_LEVEL = 8;
   localparam int CTRL_THREE_PHASE = 10;
   localparam logic [11:0] CTRL_RESET = 12'h000;
   // Bits that hold state; reserved bits are dropped and read zero
   localparam logic [11:0] CTRL_MASK = 12'h5f8;

   // System status fields
   localparam int STAT_CONV_DONE = 0;
   localparam int STAT_XF_DONE = 1;
   localparam int STAT_RESULT_VALID = 4;
   localparam int STAT_IRQ_SOURCE = 11;
   localparam logic STAT_VALID_RESET = 1'b0;

   // Conversion results carry eleven significant bits
   localparam logic [11:0] CONV_LSB_CLEAR = 12'hffe;

   // Edge-mode interrupt pulse width
   localparam int IRQ_PULSE_NS = 200;
   localparam logic [3:0] IRQ_PULSE_CYC = 4'((IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// File: tb.sv
// Self-checking bench for the control and status block.
// Assumes the host model for bus cycles; converter and datapath driven here.
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb;
   logic i_clock, rst_b, cs_b, rd_b, wr_b, oe, irq_oe, cv, cdone, u_en, aux_en, fwd, rev, three, xdone, sys_en;
   logic [3:0] addr;
   logic [1:0] chan;
   logic [11:0] hd, dd, cd, ang, in1, in2, in3, q, c, a1, a2;
   logic [11:0] res [4];
   logic [11:0] cexp [4];
   logic [3:0] caddr [4] = '{4'h8, 4'h5, 4'h6, 4'h7};
   int seed = 10, error_cnt = 0, check_count = 0, nfwd = 0, nrev = 0, nirq = 0, n0;
   mcc_host_model host_u (.i_clock(i_clock), .i_data(dd), .o_cs_b(cs_b), .o_rd_b(rd_b), .o_wr_b(wr_b),
      .o_addr(addr), .o_data(hd));
   mcc_ctrl_status dut_u (.i_clock(i_clock), .i_rst_b(rst_b), .i_cs_b(cs_b), .i_rd_b(rd_b), .i_wr_b(wr_b),
      .i_addr(addr), .i_data(hd), .o_data(dd), .o_data_oe(oe), .o_irq_b(), .o_irq_oe(irq_oe),
      .i_conv_valid(cv), .i_conv_chan(chan), .i_conv_data(cd), .i_conv_done(cdone), .o_conv_u_en(u_en),
      .o_conv_aux_en(aux_en), .o_xf_fwd_start(fwd), .o_xf_rev_start(rev), .o_xf_angle(ang), .o_xf_in_1(in1),
      .o_xf_in_2(in2), .o_xf_in_3(in3), .o_xf_three_phase(three), .i_xf_done(xdone), .i_xf_res_0(res[0]),
      .i_xf_res_1(res[1]), .i_xf_res_2(res[2]), .i_xf_res_3(res[3]), .o_sys_clk_en(sys_en));
   function automatic logic [11:0] conv_exp(input logic [11:0] d);
      return {d[11:1], 1'b0};
   endfunction
   task automatic give_verdict;
      if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      @(negedge i_clock);
      s = 1'b1;
      @(negedge i_clock);
      s = 1'b0;
      repeat (8) @(negedge i_clock);
   endtask
   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      nfwd += fwd;
      nrev += rev;
      nirq += irq_oe;
   end
   initial begin
      {rst_b, cv, chan, cd, cdone, xdone} = '0;
      foreach (res[i]) res[i] = 12'h000;
      repeat (16) @(negedge i_clock);
      rst_b = 1'b1;
      host_u.rd(4'he, q); `CHK(q, 12'h000)
      host_u.rd(4'hd, q); `CHK(q, mcc_pkg::CTRL_RESET)
      for (int i = 0; i < 4; i++) begin
         // Divide and three-phase always set, lowest bits zero
         c = (12'($random(seed)) & 12'hbc0) | 12'(i << 3) | 12'h420;
         host_u.wr(4'hd, c);
         host_u.rd(4'hd, q); `CHK(q, c & mcc_pkg::CTRL_MASK)
         `CHK({aux_en, u_en}, 2'(i))
         `CHK(three, 1'b1)
      end
      @(negedge i_clock); q[0] = sys_en;
      @(negedge i_clock); `CHK(sys_en, ~q[0])
      for (int i = 0; i < 4; i++) begin
         @(negedge i_clock);
         {cv, chan, cd} = {1'b1, 2'(i), 12'($random(seed))};
         cexp[i] = conv_exp(cd);
         @(negedge i_clock); cv = 1'b0;
      end
      for (int i = 0; i < 4; i++) begin
         host_u.rd(caddr[i], q); `CHK(q, cexp[i])
      end
      host_u.wr(4'hb, 12'hfff);
      host_u.rd(4'hd, q); `CHK(q, c & mcc_pkg::CTRL_MASK)
      host_u.rd(4'hf, q); `CHK(q, 12'h000)
      host_u.rd(4'h4, q); `CHK(q, 12'h000)
      host_u.wr(4'hd, 12'h460);
      {a1, a2} = {12'($random(seed)), 12'($random(seed))};
      host_u.wr(4'h1, a1);
      host_u.wr(4'h2, a2);
      n0 = nfwd;
      host_u.wr(4'h4, 12'h800);
      `CHK(nfwd - n0, 1)
      `CHK({in1, in2}, {a1, a2})
      `CHK(ang, 12'h800)
      host_u.rd(4'he, q); `CHK(q, 12'h000)
      foreach (res[i]) res[i] = 12'($random(seed));
      pulse(xdone);
      host_u.rd(4'he, q); `CHK(q, 12'h812)
      for (int i = 0; i < 4; i++) begin
         host_u.rd(4'(i), q); `CHK(q, res[i])
      end
      host_u.rd(4'he, q); `CHK(q, 12'h010)
      host_u.wr(4'h3, a1);
      n0 = nrev;
      host_u.wr(4'h0, 12'hfff);
      `CHK(nrev - n0, 1)
      `CHK({in3, ang}, {a1, 12'hfff})
      host_u.wr(4'hd, 12'h4a0);
      n0 = nirq;
      pulse(cdone);
      `CHK(nirq - n0, int'(mcc_pkg::IRQ_PULSE_CYC))
      host_u.rd(4'he, q); `CHK(q, 12'h801)
      host_u.rd(4'he, q); `CHK(q, 12'h000)
      host_u.wr(4'hd, 12'h5a0);
      pulse(cdone);
      repeat (12) @(negedge i_clock);
      `CHK(irq_oe, 1'b1)
      host_u.rd(4'he, q);
      `CHK(irq_oe, 1'b0)
      host_u.wr(4'hd, 12'h420);
      n0 = nirq;
      pulse(cdone);
      pulse(xdone);
      host_u.rd(4'he, q); `CHK(q, 12'h010)
      `CHK(nirq - n0, 0)
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge i_clock);
      error_cnt++;
      give_verdict();
   end
endmodule
